// ---- rtcatc_defines.svh ----
// Register offsets, field positions, reset values and divider constants
`ifndef RTCATC_DEFINES_SVH
`define RTCATC_DEFINES_SVH

`define RTCATC_ADDR_W 4
`define RTCATC_OFS_CTRL 4'h0
`define RTCATC_OFS_BANK 4'h1
`define RTCATC_OFS_ALM_MIN 4'h2
`define RTCATC_OFS_ALM_HOUR 4'h3
`define RTCATC_OFS_ALM_DATE 4'h4
`define RTCATC_OFS_ALM_WDAY 4'h5
`define RTCATC_OFS_SECONDS 4'h6

`define RTCATC_CTRL_RESET 8'hc7
`define RTCATC_CTRL_ONE_SECOND_PULSE_DISABLE_BIT 7
`define RTCATC_CTRL_SIXTEENTH_PULSE_DISABLE_BIT 6
`define RTCATC_CTRL_PRST_BIT 5
`define RTCATC_CTRL_AINIT_BIT 4

`define RTCATC_BANK_IRQEN_BIT 7
`define RTCATC_BANK_ADJUST_BIT 4
`define RTCATC_BANK_RUN_BIT 3
`define RTCATC_BANK_ALMEN_BIT 2
`define RTCATC_BANK_SEL_BIT 0

`define RTCATC_ALM_INIT_MIN 8'h00
`define RTCATC_ALM_INIT_HOUR 8'h00
`define RTCATC_ALM_INIT_DATE 8'h01
`define RTCATC_ALM_INIT_WDAY 8'h00

`define RTCATC_LS_HZ 32768
`define RTCATC_PRESC_MAX 15'h7fff
`define RTCATC_PRESC16_MAX 11'h7ff
`define RTCATC_SEC_LAST 6'h3b
`define RTCATC_SEC_HALF 6'h1e

`endif

// ---- rtcatc_pkg.sv ----
// Types shared by the alarm and tick control block
package rtcatc_pkg;

   // Minute, hour, date and weekday as held in either bank
   typedef struct packed {
      logic [7:0] minute;
      logic [7:0] hour;
      logic [7:0] date;
      logic [7:0] weekday;
   } rtcatc_time_s;

   // Which event drives the alarm pin and interrupt line
   typedef enum logic [1:0] {
      RTCATC_SRC_NONE = 2'h0,
      RTCATC_SRC_ALARM = 2'h1,
      RTCATC_SRC_1HZ = 2'h2,
      RTCATC_SRC_16HZ = 2'h3
   } rtcatc_src_e;

   // Output pulse state, one-hot
   typedef enum logic [1:0] {
      RTCATC_PULSE_IDLE = 2'b01,
      RTCATC_PULSE_LOW = 2'b10
   } rtcatc_pulse_e;

endpackage

// ---- rtcatc_top.sv ----
// Alarm, prescaler and pulse control of the calendar clock
// Function
// - Alarm initialise loads 00 min, 00 hr, day 01, Sunday.
// - Prescaler reset sampled on slow clock, readable pending.
// - Prescaler divides 32.768 kHz down to 1 Hz.
// - 1 Hz interrupt coincides with seconds count-up.
// - First tick one second after prescaler reset.
// - Run enable low stops counting, prescaler keeps going.
// - Bank select opens alarm bank; pin source selectable.
// - Interrupt pulse with pin pulse, one slow cycle.
// - Clock bank equals alarm bank drives alarm pulse.
// - Alarm updates take effect on slow clock.
// - Source 1 Hz gives 1 Hz pulse train.
// - Source 16 Hz gives 16 Hz pulse train.
// - Adjust clears seconds, carries minute from 30.
`timescale 1ns/1ps
`default_nettype none
`include "rtcatc_defines.svh"

module rtcatc_top (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [`RTCATC_ADDR_W-1:0] reg_addr_in,
   input wire logic [7:0] reg_wr_data_in,
   input wire logic reg_wr_strobe_in,
   input wire logic reg_rd_strobe_in,
   output logic [7:0] reg_rd_data_out,
   input wire logic low_speed_clk_in,
   input wire rtcatc_pkg::rtcatc_time_s clock_bank_in,
   output logic minute_carry_out,
   output logic alarm_output_pin_n_out,
   output logic rtc_interrupt_line_n_out
);

   // Slow clock synchroniser and edge detector
   logic ls_sync1_q, ls_sync2_q, ls_prev_q;
   logic ls_tick;
   // Control fields
   logic one_second_pulse_disable_q, one_second_pulse_disable_d;
   logic sixteenth_pulse_disable_q, sixteenth_pulse_disable_d;
   logic prescaler_reset_request_q, prescaler_reset_request_d;
   logic [2:0] ctrl_low_q, ctrl_low_d; // Stored as written
   logic interrupt_output_enable_q, interrupt_output_enable_d;
   logic adjust_q, adjust_d;
   logic clock_run_enable_q, clock_run_enable_d;
   logic alarm_enable_q, alarm_enable_d;
   logic bank_sel_q, bank_sel_d; // 1 selects alarm bank
   // Alarm bank as software sees it, and the copy the comparator uses
   rtcatc_pkg::rtcatc_time_s alarm_q, alarm_d;
   rtcatc_pkg::rtcatc_time_s alarm_shadow_q, alarm_shadow_d;
   // Dividers
   logic [14:0] presc_q, presc_d;
   logic [5:0] sec_q, sec_d;
   logic match_prev_q, match_prev_d;
   logic minute_carry_q, minute_carry_d;
   // Pulse generator
   rtcatc_pkg::rtcatc_pulse_e pulse_q, pulse_d;
   logic alarm_n_q, alarm_n_d;
   logic irq_n_q, irq_n_d;
   logic [7:0] rd_data_q, rd_data_d;
   // Derived terms
   logic hz1, hz16, match_now, event_now;
   rtcatc_pkg::rtcatc_src_e src;

   // Two flops before any logic looks at the slow clock
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ls_sync1_q <= 1'b0;
         ls_sync2_q <= 1'b0;
         ls_prev_q <= 1'b0;
      end else begin
         ls_sync1_q <= low_speed_clk_in;
         ls_sync2_q <= ls_sync1_q;
         ls_prev_q <= ls_sync2_q;
      end
   end

   // One fast cycle per rising slow-clock edge
   assign ls_tick = ls_sync2_q & ~ls_prev_q;

   // Divider taps; a pending prescaler reset suppresses both
   assign hz1 = (presc_q == `RTCATC_PRESC_MAX) & ~prescaler_reset_request_q;
   assign hz16 = (presc_q[10:0] == `RTCATC_PRESC16_MAX)
                 & ~prescaler_reset_request_q;

   // Alarm match against the slow-clock copy of the alarm bank
   assign match_now = (clock_bank_in == alarm_shadow_q);

   // Source selection from pulse disables and alarm enable
   always_comb begin
      unique case ({one_second_pulse_disable_q, sixteenth_pulse_disable_q,
                    alarm_enable_q})
         3'b111: src = rtcatc_pkg::RTCATC_SRC_ALARM;
         3'b010: src = rtcatc_pkg::RTCATC_SRC_1HZ;
         3'b100: src = rtcatc_pkg::RTCATC_SRC_16HZ;
         default: src = rtcatc_pkg::RTCATC_SRC_NONE;
      endcase
   end

   // Event for this slow cycle; nothing leaves while interrupts are off
   always_comb begin
      unique case (src)
         rtcatc_pkg::RTCATC_SRC_ALARM: event_now = match_now & ~match_prev_q;
         rtcatc_pkg::RTCATC_SRC_1HZ: event_now = hz1;
         rtcatc_pkg::RTCATC_SRC_16HZ: event_now = hz16;
         default: event_now = 1'b0;
      endcase
   end

   // Next state: slow-clock work first, bus writes last so a set wins
   always_comb begin
      one_second_pulse_disable_d = one_second_pulse_disable_q;
      sixteenth_pulse_disable_d = sixteenth_pulse_disable_q;
      prescaler_reset_request_d = prescaler_reset_request_q;
      ctrl_low_d = ctrl_low_q;
      interrupt_output_enable_d = interrupt_output_enable_q;
      adjust_d = adjust_q;
      clock_run_enable_d = clock_run_enable_q;
      alarm_enable_d = alarm_enable_q;
      bank_sel_d = bank_sel_q;
      alarm_d = alarm_q;
      alarm_shadow_d = alarm_shadow_q;
      presc_d = presc_q;
      sec_d = sec_q;
      match_prev_d = match_prev_q;
      minute_carry_d = 1'b0;
      pulse_d = pulse_q;
      rd_data_d = 8'h00;
      if (ls_tick) begin
         // Alarm edits reach the comparator one slow cycle late
         alarm_shadow_d = alarm_q;
         match_prev_d = match_now;
         if (prescaler_reset_request_q) begin
            // Restart from zero so the next tick is a full second away
            presc_d = 15'h0000;
            prescaler_reset_request_d = 1'b0;
         end else begin
            presc_d = presc_q + 15'h0001;
         end
         if (hz1 && clock_run_enable_q) begin
            if (adjust_q) begin
               // Carry only when at least half a minute had passed
               minute_carry_d = (sec_q >= `RTCATC_SEC_HALF);
               sec_d = 6'h00;
               adjust_d = 1'b0;
            end else if (sec_q == `RTCATC_SEC_LAST) begin
               minute_carry_d = 1'b1;
               sec_d = 6'h00;
            end else begin
               sec_d = sec_q + 6'h01;
            end
         end
         // One slow cycle of low, then release
         unique case (pulse_q)
            rtcatc_pkg::RTCATC_PULSE_IDLE: begin
               if (event_now && interrupt_output_enable_q) begin
                  pulse_d = rtcatc_pkg::RTCATC_PULSE_LOW;
               end
            end
            rtcatc_pkg::RTCATC_PULSE_LOW: begin
               pulse_d = rtcatc_pkg::RTCATC_PULSE_IDLE;
            end
         endcase
      end
      if (reg_wr_strobe_in) begin
         unique case (reg_addr_in)
            `RTCATC_OFS_CTRL: begin
               // Full-byte write; pending request can only be set here
               one_second_pulse_disable_d =
                  reg_wr_data_in[`RTCATC_CTRL_ONE_SECOND_PULSE_DISABLE_BIT];
               sixteenth_pulse_disable_d =
                  reg_wr_data_in[`RTCATC_CTRL_SIXTEENTH_PULSE_DISABLE_BIT];
               ctrl_low_d = reg_wr_data_in[2:0];
               if (reg_wr_data_in[`RTCATC_CTRL_PRST_BIT]) begin
                  prescaler_reset_request_d = 1'b1;
               end
               if (reg_wr_data_in[`RTCATC_CTRL_AINIT_BIT]) begin
                  alarm_d.minute = `RTCATC_ALM_INIT_MIN;
                  alarm_d.hour = `RTCATC_ALM_INIT_HOUR;
                  alarm_d.date = `RTCATC_ALM_INIT_DATE;
                  alarm_d.weekday = `RTCATC_ALM_INIT_WDAY;
               end
            end
            `RTCATC_OFS_BANK: begin
               interrupt_output_enable_d =
                  reg_wr_data_in[`RTCATC_BANK_IRQEN_BIT];
               clock_run_enable_d = reg_wr_data_in[`RTCATC_BANK_RUN_BIT];
               alarm_enable_d = reg_wr_data_in[`RTCATC_BANK_ALMEN_BIT];
               bank_sel_d = reg_wr_data_in[`RTCATC_BANK_SEL_BIT];
               if (reg_wr_data_in[`RTCATC_BANK_ADJUST_BIT]) begin
                  adjust_d = 1'b1;
               end
            end
            // Alarm offsets only take writes with the bank selected; AINIT in CTRL loads the bank regardless
            `RTCATC_OFS_ALM_MIN: begin
               if (bank_sel_q) alarm_d.minute = reg_wr_data_in;
            end
            `RTCATC_OFS_ALM_HOUR: begin
               if (bank_sel_q) alarm_d.hour = reg_wr_data_in;
            end
            `RTCATC_OFS_ALM_DATE: begin
               if (bank_sel_q) alarm_d.date = reg_wr_data_in;
            end
            `RTCATC_OFS_ALM_WDAY: begin
               if (bank_sel_q) alarm_d.weekday = reg_wr_data_in;
            end
            default: begin
               // Unmapped or read-only: write ignored
            end
         endcase
      end
      if (reg_rd_strobe_in) begin
         unique case (reg_addr_in)
            `RTCATC_OFS_CTRL: rd_data_d = {one_second_pulse_disable_q,
               sixteenth_pulse_disable_q, prescaler_reset_request_q,
               2'b00, ctrl_low_q};
            `RTCATC_OFS_BANK: rd_data_d = {interrupt_output_enable_q,
               2'b00, adjust_q, clock_run_enable_q, alarm_enable_q,
               1'b0, bank_sel_q};
            `RTCATC_OFS_ALM_MIN:
               rd_data_d = bank_sel_q ? alarm_q.minute : 8'h00;
            `RTCATC_OFS_ALM_HOUR:
               rd_data_d = bank_sel_q ? alarm_q.hour : 8'h00;
            `RTCATC_OFS_ALM_DATE:
               rd_data_d = bank_sel_q ? alarm_q.date : 8'h00;
            `RTCATC_OFS_ALM_WDAY:
               rd_data_d = bank_sel_q ? alarm_q.weekday : 8'h00;
            `RTCATC_OFS_SECONDS: rd_data_d = {2'b00, sec_q};
            default: rd_data_d = 8'h00; // Unmapped reads zero
         endcase
      end
      // Pin and interrupt line move together, both straight from flops
      alarm_n_d = (pulse_d != rtcatc_pkg::RTCATC_PULSE_LOW);
      irq_n_d = (pulse_d != rtcatc_pkg::RTCATC_PULSE_LOW);
   end

   // Register everything
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         one_second_pulse_disable_q <= 1'b1;
         sixteenth_pulse_disable_q <= 1'b1;
         prescaler_reset_request_q <= 1'b0;
         ctrl_low_q <= 3'h7;
         interrupt_output_enable_q <= 1'b0;
         adjust_q <= 1'b0;
         clock_run_enable_q <= 1'b0;
         alarm_enable_q <= 1'b0;
         bank_sel_q <= 1'b0;
         alarm_q <= 32'h0000_0100;
         alarm_shadow_q <= 32'h0000_0100;
         presc_q <= 15'h0000;
         sec_q <= 6'h00;
         match_prev_q <= 1'b0;
         minute_carry_q <= 1'b0;
         pulse_q <= rtcatc_pkg::RTCATC_PULSE_IDLE;
         alarm_n_q <= 1'b1;
         irq_n_q <= 1'b1;
         rd_data_q <= 8'h00;
      end else begin
         one_second_pulse_disable_q <= one_second_pulse_disable_d;
         sixteenth_pulse_disable_q <= sixteenth_pulse_disable_d;
         prescaler_reset_request_q <= prescaler_reset_request_d;
         ctrl_low_q <= ctrl_low_d;
         interrupt_output_enable_q <= interrupt_output_enable_d;
         adjust_q <= adjust_d;
         clock_run_enable_q <= clock_run_enable_d;
         alarm_enable_q <= alarm_enable_d;
         bank_sel_q <= bank_sel_d;
         alarm_q <= alarm_d;
         alarm_shadow_q <= alarm_shadow_d;
         presc_q <= presc_d;
         sec_q <= sec_d;
         match_prev_q <= match_prev_d;
         minute_carry_q <= minute_carry_d;
         pulse_q <= pulse_d;
         alarm_n_q <= alarm_n_d;
         irq_n_q <= irq_n_d;
         rd_data_q <= rd_data_d;
      end
   end

   assign reg_rd_data_out = rd_data_q;
   assign minute_carry_out = minute_carry_q;
   assign alarm_output_pin_n_out = alarm_n_q;
   assign rtc_interrupt_line_n_out = irq_n_q;

   // Checks kept beside the logic
   sequence s_init_write;
      reg_wr_strobe_in && reg_addr_in == `RTCATC_OFS_CTRL
         && reg_wr_data_in[`RTCATC_CTRL_AINIT_BIT];
   endsequence

   sequence s_second_wrap;
      ls_tick && hz1 && clock_run_enable_q && !adjust_q
         && sec_q == `RTCATC_SEC_LAST;
   endsequence

   property p_alarm_init;
      @(posedge clk_in) disable iff (sys_rst_in)
      s_init_write |=> alarm_q == 32'h0000_0100;
   endproperty
   a_alarm_init: assert property (p_alarm_init)
      else $error("alarm init");
   property p_prst_pending;
      @(posedge clk_in) disable iff (sys_rst_in)
      reg_wr_strobe_in && reg_addr_in == `RTCATC_OFS_CTRL
         && reg_wr_data_in[`RTCATC_CTRL_PRST_BIT]
         |=> prescaler_reset_request_q;
   endproperty
   a_prst_pending: assert property (p_prst_pending)
      else $error("prst lost");
   property p_presc_clear;
      @(posedge clk_in) disable iff (sys_rst_in)
      ls_tick && prescaler_reset_request_q |=> presc_q == 15'h0000;
   endproperty
   a_presc_clear: assert property (p_presc_clear)
      else $error("presc");
   property p_minute_carry;
      @(posedge clk_in) disable iff (sys_rst_in)
      s_second_wrap |=> minute_carry_out && sec_q == 6'h00;
   endproperty
   a_minute_carry: assert property (p_minute_carry)
      else $error("carry");
   property p_stopped;
      @(posedge clk_in) disable iff (sys_rst_in)
      !clock_run_enable_q |=> $stable(sec_q) && !minute_carry_out;
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("counted stopped");
   // A fresh request written in the same cycle wins over the clear
   property p_adjust;
      @(posedge clk_in) disable iff (sys_rst_in)
      ls_tick && hz1 && clock_run_enable_q && adjust_q && !reg_wr_strobe_in
         && sec_q >= `RTCATC_SEC_HALF |=> minute_carry_out && !adjust_q;
   endproperty
   a_adjust: assert property (p_adjust)
      else $error("adjust");
   property p_pins_together;
      @(posedge clk_in) disable iff (sys_rst_in)
      rtc_interrupt_line_n_out == alarm_output_pin_n_out;
   endproperty
   a_pins_together: assert property (p_pins_together)
      else $error("pins");
   property p_low_holds;
      @(posedge clk_in) disable iff (sys_rst_in)
      !rtc_interrupt_line_n_out && !ls_tick |=> !rtc_interrupt_line_n_out;
   endproperty
   a_low_holds: assert property (p_low_holds)
      else $error("short pulse");
   property p_no_source;
      @(posedge clk_in) disable iff (sys_rst_in)
      src == rtcatc_pkg::RTCATC_SRC_NONE && rtc_interrupt_line_n_out
         |=> rtc_interrupt_line_n_out;
   endproperty
   a_no_source: assert property (p_no_source)
      else $error("no src");

endmodule // rtcatc_top
`default_nettype wire

// ---- rtcatc_top_tb.sv ----
// Self-checking bench for the alarm and tick control block
`timescale 1ns/1ps
`default_nettype none
`include "rtcatc_defines.svh"

module rtcatc_top_tb;
   localparam int SLOW_CYC = 8; // Fast cycles per slow clock period
   localparam int TICKS_16HZ = 2048; // Slow ticks between 16 Hz events
   localparam int QUIET = (TICKS_16HZ + 100) * SLOW_CYC; // Silence window
   logic clk_in = 1'b0; // Fast clock, 8 ns
   logic sys_rst_in = 1'b1; // Held high at start
   logic [`RTCATC_ADDR_W-1:0] reg_addr = 4'h0; // Register index
   logic [7:0] reg_wr_data = 8'h00; // Write data
   logic reg_wr_strobe = 1'b0; // Write strobe
   logic reg_rd_strobe = 1'b0; // Read strobe
   logic [7:0] reg_rd_data; // Read data from the block
   logic slow_clk = 1'b0; // Low-speed clock, sped up for simulation
   logic slow_run = 1'b1; // Lets a scenario freeze the slow clock
   rtcatc_pkg::rtcatc_time_s clock_bank = 32'h00000000; // Calendar values
   logic alarm_pin_n; // Alarm pin, active low
   logic irq_line_n; // Interrupt line, active low
   logic minute_carry; // Carry pulse towards the minute counter
   int errors = 0; // Mismatch count
   int n_compared = 0; // Comparison count
   int cnt; // Cycles the pin stayed low
   int waited; // Cycles spent waiting for a fall

   // Fast clock
   always #4 clk_in = ~clk_in;

   // Slow clock edges land on fast falling edges, so the phase is fixed
   always #32 if (slow_run) slow_clk = ~slow_clk;

   rtcatc_top dut (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr),
      .reg_wr_data_in(reg_wr_data),
      .reg_wr_strobe_in(reg_wr_strobe),
      .reg_rd_strobe_in(reg_rd_strobe),
      .reg_rd_data_out(reg_rd_data),
      .low_speed_clk_in(slow_clk),
      .clock_bank_in(clock_bank),
      .minute_carry_out(minute_carry),
      .alarm_output_pin_n_out(alarm_pin_n),
      .rtc_interrupt_line_n_out(irq_line_n)
   );

   // Verdict and end of run, reached from every path
   task automatic results();
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Byte comparison
   task automatic chk_byte(input string name, input logic [7:0] exp,
                           input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Single bit comparison
   task automatic chk_bit(input string name, input logic exp,
                          input logic got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s: expected %b, seen %b", name, exp, got);
      end
   endtask

   // Cycle count comparison, both values worked out by the bench
   task automatic chk_count(input string name, input int exp, input int got);
      n_compared++;
      if (got != exp) begin
         errors++;
         $display("wrong value %s: expected %0d, seen %0d", name, exp, got);
      end
   endtask

   // One-cycle write strobe beside address and data
   task automatic wr_reg(input logic [3:0] addr, input logic [7:0] data);
      @(posedge clk_in);
      reg_addr <= addr;
      reg_wr_data <= data;
      reg_wr_strobe <= 1'b1;
      @(posedge clk_in);
      reg_wr_strobe <= 1'b0;
   endtask

   // One-cycle read strobe; data is valid only in the following cycle
   task automatic rd_chk(input string name, input logic [3:0] addr,
                         input logic [7:0] exp);
      @(posedge clk_in);
      reg_addr <= addr;
      reg_rd_strobe <= 1'b1;
      @(posedge clk_in);
      reg_rd_strobe <= 1'b0;
      #1;
      chk_byte(name, exp, reg_rd_data);
   endtask

   // Bounded watch for a falling interrupt line; a missed pulse ends the run
   task automatic wait_pin(input int bound, input logic expect_fall,
                           input string name);
      logic seen;
      logic prev;
      seen = 1'b0;
      prev = irq_line_n;
      waited = 0;
      while (waited < bound && !seen) begin
         @(posedge clk_in);
         #1;
         waited++;
         // Edge, not level, as the interrupt controller sees it
         if (prev === 1'b1 && irq_line_n === 1'b0) seen = 1'b1;
         prev = irq_line_n;
      end
      chk_bit(name, expect_fall, seen);
      if (expect_fall && !seen) results();
   endtask

   // Length of the low phase in fast cycles, bounded
   task automatic measure_low();
      cnt = 0;
      while (alarm_pin_n !== 1'b1 && cnt < 1000) begin
         @(posedge clk_in);
         #1;
         cnt++;
      end
   endtask

   // Both outputs are registered alike, so they must match every cycle;
   // looked at mid-cycle, where both have settled
   always @(negedge clk_in) begin
      if (!sys_rst_in) begin
         chk_bit("interrupt line", alarm_pin_n, irq_line_n);
         // No seconds wrap fits in this run, so no carry may appear
         chk_bit("minute carry", 1'b0, minute_carry);
      end
   end

   // Main sequence
   initial begin
      repeat (5) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      #1;
      chk_bit("alarm pin idle", 1'b1, alarm_pin_n);
      rd_chk("ctrl reset", `RTCATC_OFS_CTRL, 8'hc7);
      rd_chk("bank reset", `RTCATC_OFS_BANK, 8'h00);
      rd_chk("alarm bank closed", `RTCATC_OFS_ALM_DATE, 8'h00);
      // Unmapped place and read-only seconds ignore writes
      wr_reg(4'hf, 8'h5a);
      rd_chk("unmapped", 4'hf, 8'h00);
      wr_reg(`RTCATC_OFS_SECONDS, 8'h25);
      rd_chk("seconds", `RTCATC_OFS_SECONDS, 8'h00);
      rd_chk("seconds again", `RTCATC_OFS_SECONDS, 8'h00);
      // Open the alarm bank, store values, then initialise them
      wr_reg(`RTCATC_OFS_BANK, 8'h01);
      rd_chk("alarm date open", `RTCATC_OFS_ALM_DATE, 8'h01);
      wr_reg(`RTCATC_OFS_ALM_MIN, 8'h45);
      wr_reg(`RTCATC_OFS_ALM_HOUR, 8'h17);
      wr_reg(`RTCATC_OFS_ALM_DATE, 8'h28);
      wr_reg(`RTCATC_OFS_ALM_WDAY, 8'h03);
      rd_chk("alarm minute stored", `RTCATC_OFS_ALM_MIN, 8'h45);
      wr_reg(`RTCATC_OFS_CTRL, 8'hd7);
      repeat (4 * SLOW_CYC) @(posedge clk_in);
      rd_chk("init minute", `RTCATC_OFS_ALM_MIN, 8'h00);
      rd_chk("init hour", `RTCATC_OFS_ALM_HOUR, 8'h00);
      rd_chk("init date", `RTCATC_OFS_ALM_DATE, 8'h01);
      rd_chk("init weekday", `RTCATC_OFS_ALM_WDAY, 8'h00);
      rd_chk("ctrl after init", `RTCATC_OFS_CTRL, 8'hc7);
      // Freeze the slow clock so the prescaler reset stays pending
      slow_run = 1'b0;
      // Let a tick already inside the synchroniser drain first
      repeat (SLOW_CYC) @(posedge clk_in);
      wr_reg(`RTCATC_OFS_CTRL, 8'he7);
      rd_chk("reset pending", `RTCATC_OFS_CTRL, 8'he7);
      slow_run = 1'b1;
      repeat (4 * SLOW_CYC) @(posedge clk_in);
      rd_chk("reset taken", `RTCATC_OFS_CTRL, 8'hc7);
      // Alarm set up in order, clock bank one minute short of a match
      clock_bank <= {8'h29, 8'h11, 8'h05, 8'h01};
      wr_reg(`RTCATC_OFS_ALM_MIN, 8'h30);
      wr_reg(`RTCATC_OFS_ALM_HOUR, 8'h11);
      wr_reg(`RTCATC_OFS_ALM_DATE, 8'h05);
      wr_reg(`RTCATC_OFS_ALM_WDAY, 8'h01);
      wr_reg(`RTCATC_OFS_BANK, 8'h0d);
      wr_reg(`RTCATC_OFS_BANK, 8'h8d);
      wait_pin(40 * SLOW_CYC, 1'b0, "no early alarm");
      clock_bank <= {8'h30, 8'h11, 8'h05, 8'h01};
      wait_pin(8 * SLOW_CYC, 1'b1, "alarm match");
      measure_low();
      chk_count("alarm low width", SLOW_CYC, cnt);
      wait_pin(40 * SLOW_CYC, 1'b0, "single alarm");
      // Next alarm programmed from the handler of the current one
      wr_reg(`RTCATC_OFS_ALM_MIN, 8'h31);
      clock_bank <= {8'h31, 8'h11, 8'h05, 8'h01};
      wait_pin(8 * SLOW_CYC, 1'b1, "repeat alarm");
      measure_low();
      chk_count("repeat low width", SLOW_CYC, cnt);
      // Alarm off, both pulse trains enabled: no valid source
      wr_reg(`RTCATC_OFS_BANK, 8'h88);
      rd_chk("alarm bank refused", `RTCATC_OFS_ALM_MIN, 8'h00);
      wr_reg(`RTCATC_OFS_CTRL, 8'h07);
      wait_pin(QUIET, 1'b0, "no source");
      // 16 Hz train: width and spacing
      wr_reg(`RTCATC_OFS_CTRL, 8'h87);
      wait_pin(QUIET, 1'b1, "16 Hz first");
      measure_low();
      chk_count("16 Hz low width", SLOW_CYC, cnt);
      wait_pin(QUIET, 1'b1, "16 Hz next");
      chk_count("16 Hz gap", TICKS_16HZ * SLOW_CYC, cnt + waited);
      // Let the pulse end before the quiet window starts
      measure_low();
      chk_count("16 Hz next width", SLOW_CYC, cnt);
      // Interrupt disabled holds the train back
      wr_reg(`RTCATC_OFS_BANK, 8'h08);
      wait_pin(QUIET, 1'b0, "interrupt disabled");
      // 1 Hz source must not pulse at the 16 Hz rate
      wr_reg(`RTCATC_OFS_BANK, 8'h88);
      wr_reg(`RTCATC_OFS_CTRL, 8'h47);
      wait_pin(QUIET, 1'b0, "1 Hz not at 16 Hz");
      results();
   end
endmodule // rtcatc_top_tb
`default_nettype wire
